/* File: rtl/pcs_defs.vh */
`ifndef PCS_DEFS_VH
`define PCS_DEFS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the Avalon-MM slave
`define PCS_OFS_CONTROL 4'h0
`define PCS_OFS_BANDWIDTH 4'h4
`define PCS_OFS_PROGRAMMING 4'h8

////////////////////////////////////////////////////////////////////////////////
// Control register field positions
`define PCS_CTL_IRQEN 7
`define PCS_CTL_FLAG 6
`define PCS_CTL_PLLEN 5
`define PCS_CTL_SRCSEL 4
`define PCS_CTL_UNUSED_VAL 4'hF

// Bandwidth register field positions
`define PCS_BW_AUTO 7
`define PCS_BW_LOCK 6
`define PCS_BW_ACQ 5
`define PCS_BW_XLD 4
`define PCS_BW_TEST_VAL 4'h0

// Programming register field positions
`define PCS_PRG_MULT_HI 7
`define PCS_PRG_MULT_LO 4
`define PCS_PRG_RANGE_HI 3
`define PCS_PRG_RANGE_LO 0

////////////////////////////////////////////////////////////////////////////////
// Reset values and zero/one field constants
`define PCS_MULT_RESET 4'h6
`define PCS_RANGE_RESET 4'h6
`define PCS_PLLEN_RESET 1'b1
`define PCS_MULT_ZERO 4'h0
`define PCS_MULT_ONE 4'h1
`define PCS_RANGE_ZERO 4'h0

////////////////////////////////////////////////////////////////////////////////
// Timing: source edges waited on each side of a clock switch
`define PCS_SWITCH_EDGES 2'h3
// System clock period in ns
`define PCS_CLK_PERIOD_NS 40

`endif

/* File: rtl/pcs_clock_ctrl.v */
`timescale 1ns/1ps
`include "pcs_defs.vh"

module pcs_clock_ctrl (
   input wire clk_sys,
   input wire resetn,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [3:0] byteenable,
   input wire [31:0] writedata,
   output wire [31:0] readdata,
   output wire waitrequest,
   input wire crystalClockIn,
   input wire vcoClockIn,
   input wire lockDetectIn,
   input wire acqDetectIn,
   input wire oscillatorEnableIn,
   output wire crystalClockOut,
   output wire baseClockOut,
   output wire cpuInterruptOut,
   output wire pllEnableOut,
   output wire trackingModeOut,
   output wire [3:0] vcoMultiplierOut,
   output wire [3:0] vcoRangeOut
);

   // Transition circuit states
   localparam ST_RUN = 2'b00;
   localparam ST_WAIT_OLD = 2'b01;
   localparam ST_WAIT_NEW = 2'b10;
   // Pin index into the synchroniser bank
   localparam PIN_XTAL = 0;
   localparam PIN_VCO = 1;
   localparam PIN_LOCK = 2;
   localparam PIN_ACQ = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Address match, shared by read mux and write decode
   function regHit;
      input [3:0] addr;
      input [3:0] offset;
      begin
         regHit = (addr == offset);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers; a level counts once stages two and three agree.
   // Source clocks are sampled, so they must stay well below a quarter of clk_sys.
   wire [3:0] pinIn;
   wire [3:0] pinStable;
   wire [3:0] pinRise;
   assign pinIn = {acqDetectIn, lockDetectIn, vcoClockIn, crystalClockIn};

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : gSync
         reg s1Q;
         reg s2Q;
         reg s3Q;
         reg stableQ;
         reg prevQ;
         // Stage one feeds only stage two
         always @(posedge clk_sys or negedge resetn) begin
            if (!resetn) begin
               s1Q <= 1'b0;
               s2Q <= 1'b0;
               s3Q <= 1'b0;
               stableQ <= 1'b0;
               prevQ <= 1'b0;
            end else begin
               s1Q <= pinIn[gi];
               s2Q <= s1Q;
               s3Q <= s2Q;
               if (s2Q == s3Q) begin
                  stableQ <= s3Q;
               end
               prevQ <= stableQ;
            end
         end
         assign pinStable[gi] = stableQ;
         assign pinRise[gi] = stableQ & ~prevQ;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave: one wait cycle, then the access completes
   reg waitQ;
   reg [31:0] readDataQ;
   wire rdAccept;
   wire wrAccept;
   wire hitCtl;
   wire hitBw;
   wire hitPrg;
   wire wrCtl;
   wire wrBw;
   wire wrPrg;
   assign rdAccept = read & ~waitQ;
   assign wrAccept = write & ~waitQ & byteenable[0];
   assign hitCtl = regHit(address, `PCS_OFS_CONTROL);
   assign hitBw = regHit(address, `PCS_OFS_BANDWIDTH);
   assign hitPrg = regHit(address, `PCS_OFS_PROGRAMMING);
   assign wrCtl = wrAccept & hitCtl;
   assign wrBw = wrAccept & hitBw;
   assign wrPrg = wrAccept & hitPrg;

   ////////////////////////////////////////////////////////////////////////////
   // Register state
   reg irqEnQ;
   reg flagQ;
   reg pllEnQ;
   reg srcSelQ;
   reg autoQ;
   reg lockQ;
   reg manualAcqQ;
   reg xldQ;
   reg [3:0] multQ;
   reg [3:0] rangeQ;
   reg activeVcoQ;
   wire stopping;
   wire rangeZero;
   wire acqView;
   wire lockToggle;
   assign stopping = ~oscillatorEnableIn;
   assign rangeZero = (rangeQ == `PCS_RANGE_ZERO);
   assign acqView = autoQ ? pinStable[PIN_ACQ] : manualAcqQ;
   assign lockToggle = autoQ & (pinStable[PIN_LOCK] != lockQ);
   // Read mux, sampled in the wait cycle
   reg [7:0] rdByte;
   always @* begin
      rdByte = 8'h00;
      if (hitCtl) begin
         rdByte[`PCS_CTL_IRQEN] = irqEnQ & autoQ;
         rdByte[`PCS_CTL_FLAG] = flagQ & autoQ;
         rdByte[`PCS_CTL_PLLEN] = pllEnQ;
         rdByte[`PCS_CTL_SRCSEL] = srcSelQ;
         rdByte[3:0] = `PCS_CTL_UNUSED_VAL;
      end else if (hitBw) begin
         rdByte[`PCS_BW_AUTO] = autoQ;
         rdByte[`PCS_BW_LOCK] = lockQ;
         rdByte[`PCS_BW_ACQ] = acqView;
         rdByte[`PCS_BW_XLD] = xldQ & srcSelQ;
         rdByte[3:0] = `PCS_BW_TEST_VAL;
      end else if (hitPrg) begin
         rdByte[`PCS_PRG_MULT_HI:`PCS_PRG_MULT_LO] = multQ;
         rdByte[`PCS_PRG_RANGE_HI:`PCS_PRG_RANGE_LO] = rangeQ;
      end
   end
   // Handshake; unmapped addresses read zero and ignore writes
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         waitQ <= 1'b1;
         readDataQ <= 32'h00000000;
      end else if ((read || write) && waitQ) begin
         waitQ <= 1'b0;
         readDataQ <= {24'h000000, rdByte};
      end else begin
         waitQ <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control register: interlocks use the pre-write values, so one write can neither enable and select nor deselect and disable
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         irqEnQ <= 1'b0;
         pllEnQ <= `PCS_PLLEN_RESET;
         srcSelQ <= 1'b0;
      end else begin
         if (wrCtl && autoQ) begin
            irqEnQ <= writedata[`PCS_CTL_IRQEN];
         end
         if (wrCtl) begin
            if (writedata[`PCS_CTL_PLLEN] || !srcSelQ) begin
               pllEnQ <= writedata[`PCS_CTL_PLLEN];
            end
         end
         if (stopping || rangeZero) begin
            srcSelQ <= 1'b0;
         end else if (wrCtl) begin
            if (!writedata[`PCS_CTL_SRCSEL] || pllEnQ) begin
               srcSelQ <= writedata[`PCS_CTL_SRCSEL];
            end
         end
      end
   end
   // Lock change flag: a toggle in the clearing cycle wins; only a flag the read returned is cleared
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         flagQ <= 1'b0;
      end else if (!autoQ) begin
         flagQ <= 1'b0;
      end else if (lockToggle) begin
         flagQ <= 1'b1;
      end else if (rdAccept && hitCtl && readDataQ[`PCS_CTL_FLAG]) begin
         flagQ <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bandwidth register
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         autoQ <= 1'b0;
         lockQ <= 1'b0;
         manualAcqQ <= 1'b0;
      end else begin
         if (wrBw) begin
            autoQ <= writedata[`PCS_BW_AUTO];
         end
         // Lock follows the detector only in automatic mode
         lockQ <= autoQ & pinStable[PIN_LOCK];
         // Held while automatic, so manual mode gets it back
         if (wrBw && !autoQ) begin
            manualAcqQ <= writedata[`PCS_BW_ACQ];
         end
      end
   end

   // Crystal loss: armed by writing one while the VCO drives the output, cleared by the next crystal edge.
   // A live crystal clears it well inside the N times four cycle wait that software observes.
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         xldQ <= 1'b0;
      end else if (!activeVcoQ) begin
         xldQ <= 1'b0;
      end else if (wrBw) begin
         xldQ <= writedata[`PCS_BW_XLD];
      end else if (pinRise[PIN_XTAL]) begin
         xldQ <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Programming register, frozen while the loop is enabled
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         multQ <= `PCS_MULT_RESET;
         rangeQ <= `PCS_RANGE_RESET;
      end else if (wrPrg && !pllEnQ) begin
         multQ <= writedata[`PCS_PRG_MULT_HI:`PCS_PRG_MULT_LO];
         rangeQ <= writedata[`PCS_PRG_RANGE_HI:`PCS_PRG_RANGE_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transition circuit: count old-source edges, then new-source edges
   reg [1:0] stateQ;
   reg [1:0] stateD;
   reg [1:0] edgeCntQ;
   reg [1:0] edgeCntD;
   reg activeVcoD;
   wire oldRise;
   wire newRise;
   assign oldRise = activeVcoQ ? pinRise[PIN_VCO] : pinRise[PIN_XTAL];
   assign newRise = activeVcoQ ? pinRise[PIN_XTAL] : pinRise[PIN_VCO];
   always @* begin
      stateD = stateQ;
      edgeCntD = edgeCntQ;
      activeVcoD = activeVcoQ;
      case (stateQ)
         ST_RUN: begin
            if (srcSelQ != activeVcoQ) begin
               stateD = ST_WAIT_OLD;
               edgeCntD = 2'h0;
            end
         end
         ST_WAIT_OLD: begin
            if (oldRise) begin
               if (edgeCntQ == `PCS_SWITCH_EDGES - 2'h1) begin
                  stateD = ST_WAIT_NEW;
                  edgeCntD = 2'h0;
               end else begin
                  edgeCntD = edgeCntQ + 2'h1;
               end
            end
         end
         ST_WAIT_NEW: begin
            if (newRise) begin
               if (edgeCntQ == `PCS_SWITCH_EDGES - 2'h1) begin
                  stateD = ST_RUN;
                  activeVcoD = srcSelQ;
               end else begin
                  edgeCntD = edgeCntQ + 2'h1;
               end
            end
         end
         default: begin
            stateD = ST_RUN;
            edgeCntD = 2'h0;
         end
      endcase
   end
   // Stop drops straight back to the crystal, nothing to hand over
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         stateQ <= ST_RUN;
         edgeCntQ <= 2'h0;
         activeVcoQ <= 1'b0;
      end else if (stopping) begin
         stateQ <= ST_RUN;
         edgeCntQ <= 2'h0;
         activeVcoQ <= 1'b0;
      end else begin
         stateQ <= stateD;
         edgeCntQ <= edgeCntD;
         activeVcoQ <= activeVcoD;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs
   reg baseClockQ;
   reg crystalClockQ;
   reg irqQ;
   reg pllEnOutQ;
   reg trackingQ;
   reg [3:0] multOutQ;
   reg [3:0] rangeOutQ;

   // Base clock toggles once per source edge; frozen from the select change, not one edge later
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         baseClockQ <= 1'b0;
      end else if (stopping) begin
         baseClockQ <= 1'b0;
      end else if (stateQ == ST_RUN && srcSelQ == activeVcoQ && oldRise) begin
         baseClockQ <= ~baseClockQ;
      end
   end

   // Crystal clock, interrupt and loop control outputs; the divider never sees zero
   always @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
         crystalClockQ <= 1'b0;
         irqQ <= 1'b0;
         pllEnOutQ <= 1'b0;
         trackingQ <= 1'b0;
         multOutQ <= `PCS_MULT_RESET;
         rangeOutQ <= `PCS_RANGE_RESET;
      end else begin
         crystalClockQ <= oscillatorEnableIn & pinStable[PIN_XTAL];
         irqQ <= oscillatorEnableIn & autoQ & irqEnQ & flagQ;
         pllEnOutQ <= oscillatorEnableIn & pllEnQ & ~rangeZero;
         trackingQ <= acqView;
         if (multQ == `PCS_MULT_ZERO) begin
            multOutQ <= `PCS_MULT_ONE;
         end else begin
            multOutQ <= multQ;
         end
         rangeOutQ <= rangeQ;
      end
   end

   assign readdata = readDataQ;
   assign waitrequest = waitQ;
   assign crystalClockOut = crystalClockQ;
   assign baseClockOut = baseClockQ;
   assign cpuInterruptOut = irqQ;
   assign pllEnableOut = pllEnOutQ;
   assign trackingModeOut = trackingQ;
   assign vcoMultiplierOut = multOutQ;
   assign vcoRangeOut = rangeOutQ;
endmodule // pcs_clock_ctrl

/* File: test/pcs_checker.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pcs_checker (
   input wire clk_sys,
   input wire resetn,
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] readdata,
   input wire waitrequest,
   input wire oscillatorEnableIn,
   input wire crystalClockOut,
   input wire baseClockOut,
   input wire cpuInterruptOut,
   input wire pllEnableOut,
   input wire [3:0] vcoMultiplierOut,
   input wire [3:0] vcoRangeOut
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   // Bus: one low wait cycle per request, taken on the next edge
   a_wait_single: assert property (!waitrequest |=> waitrequest) else $error("ack longer than one cycle");
   a_req_answer: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("request not answered");
   a_rd_upper: assert property (!waitrequest && read |-> readdata[31:8] == 24'h0) else $error("upper read bits set");
   a_unmapped_zero: assert property (!waitrequest && read && !(address inside {4'h0, 4'h4, 4'h8})
      |-> readdata == 32'h0) else $error("unmapped read not zero");

   // Register contents seen at the bus and at the loop control outputs
   a_ctl_ones: assert property (!waitrequest && read && address == 4'h0 |-> readdata[3:0] == 4'hF)
      else $error("control low nibble not ones");
   a_prog_locked: assert property (!waitrequest && write && address == 4'h8 && pllEnableOut
      |=> ($stable(vcoMultiplierOut) && $stable(vcoRangeOut))[*2]) else $error("programming written while on");
   a_mult_nonzero: assert property (vcoMultiplierOut != 4'h0) else $error("multiplier zero at divider");
   a_range_off: assert property (vcoRangeOut == 4'h0 |-> !pllEnableOut) else $error("loop on with range zero");

   // Interrupt follows flag and enable, which the control read reveals
   a_irq_gated: assert property (!waitrequest && read && address == 4'h0 && !readdata[7]
      |=> !cpuInterruptOut[*2]) else $error("interrupt while disabled");
   a_irq_flag: assert property (!waitrequest && read && address == 4'h0 && readdata[7:6] == 2'b11
      && $past(oscillatorEnableIn) |-> cpuInterruptOut) else $error("interrupt missing");

   // Stop and clock shape; a stop may cut a half period short, so it ends the check
   a_stop_quiet: assert property (!oscillatorEnableIn
      |=> !(crystalClockOut || baseClockOut || cpuInterruptOut)) else $error("outputs active in stop");
   a_base_steady: assert property (@(posedge clk_sys) disable iff (!resetn || !oscillatorEnableIn)
      $changed(baseClockOut) |=> $stable(baseClockOut)[*4]) else $error("base clock half period short");
endmodule // pcs_checker

bind pcs_clock_ctrl pcs_checker u_checker (.clk_sys(clk_sys), .resetn(resetn), .address(address),
   .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest),
   .oscillatorEnableIn(oscillatorEnableIn), .crystalClockOut(crystalClockOut), .baseClockOut(baseClockOut),
   .cpuInterruptOut(cpuInterruptOut), .pllEnableOut(pllEnableOut), .vcoMultiplierOut(vcoMultiplierOut),
   .vcoRangeOut(vcoRangeOut));

/* File: test/pcs_far_model.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module pcs_far_model (
   input wire clk_sys,
   input wire stopReq,
   input wire xtalHalt,
   input wire lockReq,
   input wire acqReq,
   output logic crystalClk,
   output logic vcoClk,
   output wire lockLevel,
   output wire acqLevel,
   output logic oscEnable
);
   // Sources start low; phases are unrelated to the system clock on purpose
   // Crystal can be halted to emulate a lost reference
   initial begin
      crystalClk = 1'b0;
      forever #210 if (!xtalHalt) crystalClk = !crystalClk;
   end
   initial begin
      vcoClk = 1'b0;
      forever #130 vcoClk = !vcoClk;
   end

   // Stop control is issued in the system clock domain
   always @(posedge clk_sys) oscEnable <= !stopReq;

   // Analog detectors settle a while after the loop changes
   assign #170 lockLevel = lockReq;
   assign #170 acqLevel = acqReq;
endmodule // pcs_far_model

/* File: test/tb.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] address = 4'h0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [31:0] writedata = 32'h0;
   logic stopReq = 1'b0;
   logic xtalHalt = 1'b0;
   logic lockReq = 1'b0;
   logic acqReq = 1'b0;
   wire [31:0] readdata;
   wire waitrequest, xClk, vClk, lockLvl, acqLvl, oscEn, xOut, baseOut, irqOut, pll_enable, trk;
   wire [3:0] mult, rng;
   int n_errors = 0;
   int num_checks = 0;
   bit pllEn = 1, sel = 0, irqEn = 0, auto = 0, acqM = 0;
   logic [7:0] prog = 8'h66;
   logic [7:0] vals [$];
   time t0;

   always #20 clk_sys = !clk_sys;

   pcs_far_model u_far (.clk_sys(clk_sys), .stopReq(stopReq), .xtalHalt(xtalHalt), .lockReq(lockReq),
      .acqReq(acqReq), .crystalClk(xClk), .vcoClk(vClk), .lockLevel(lockLvl), .acqLevel(acqLvl),
      .oscEnable(oscEn));

   pcs_clock_ctrl DUT (.clk_sys(clk_sys), .resetn(resetn), .address(address), .read(read), .write(write),
      .byteenable(4'hF), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .crystalClockIn(xClk), .vcoClockIn(vClk), .lockDetectIn(lockLvl), .acqDetectIn(acqLvl),
      .oscillatorEnableIn(oscEn), .crystalClockOut(xOut), .baseClockOut(baseOut), .cpuInterruptOut(irqOut),
      .pllEnableOut(pll_enable), .trackingModeOut(trk), .vcoMultiplierOut(mult), .vcoRangeOut(rng));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // One Avalon access; request held until waitrequest is sampled low
   task automatic bus(input bit w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      @(posedge clk_sys);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h0, d};
      @(posedge clk_sys);
      while (waitrequest !== 1'b0 && n < 20) begin
         n++;
         @(posedge clk_sys);
      end
      q = readdata[7:0];
      if (n >= 20) chk("bus_answer", 8'h1, 8'h0);
      read <= 1'b0;
      write <= 1'b0;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      bus(1'b0, a, 8'h00, q);
      num_checks++;
      if (q !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, e, q);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Shadow of the control interlocks: decisions use the bits as they were before the write
   task automatic wctl(input logic [7:0] d);
      bit p;
      p = pllEn;
      if (auto) irqEn = d[7];
      if (!(sel && !d[5])) pllEn = d[5];
      if (!(d[4] && !p)) sel = d[4] && prog[3:0] != 4'h0;
      wr(4'h0, d);
   endtask

   task automatic wbw(input logic [7:0] d);
      if (!auto) acqM = d[5];
      auto = d[7];
      wr(4'h4, d);
   endtask

   function automatic logic [7:0] ctlv(input bit f);
      return {irqEn & auto, f & auto, pllEn, sel, 4'hF};
   endfunction

   function automatic logic [7:0] bwv(input bit lk, input bit x);
      return {auto, lk & auto, auto ? acqReq : acqM, x & sel, 4'h0};
   endfunction

   // Time from a base clock edge (or from now) to its next change
   task automatic span(input string nm, input int lo, input int hi, input bit sync);
      int d;
      if (sync) @(posedge baseOut);
      else @(posedge clk_sys);
      t0 = $time;
      @(baseOut);
      d = int'($time - t0);
      chk(nm, 8'h1, {7'h0, d >= lo && d <= hi});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Watchdog: whole sequence needs well under a millisecond
   initial begin
      #1000000;
      n_errors++;
      end_sim();
   end

   initial begin
      void'($urandom(32'h4211));
      repeat (12) @(posedge clk_sys);
      resetn <= 1'b1;
      rd_chk("ctl", 4'h0, 8'h2F);
      rd_chk("bw", 4'h4, 8'h00);
      rd_chk("prog", 4'h8, 8'h66);
      rd_chk("unmapped", 4'hC, 8'h00);
      wr(4'h8, 8'h11);
      rd_chk("prog", 4'h8, prog);
      wctl(8'h00);
      vals = {8'h05, 8'($urandom), 8'($urandom), 8'h80};
      foreach (vals[i]) begin
         wr(4'h8, vals[i]);
         prog = vals[i];
         rd_chk("prog", 4'h8, prog);
         chk("mult", prog[7:4] == 4'h0 ? 8'h1 : {4'h0, prog[7:4]}, {4'h0, mult});
         chk("range", {4'h0, prog[3:0]}, {4'h0, rng});
      end
      // Range zero: loop enable written but output held off, source select blocked
      wctl(8'h20);
      wctl(8'h30);
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      chk("pll_on", 8'h0, {7'h0, pll_enable});
      wctl(8'h00);
      wr(4'h8, 8'h86);
      prog = 8'h86;
      wctl(8'h10);
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      wctl(8'h30);
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      span("xtal_half", 360, 480, 1'b1);
      wctl(8'h30);
      span("switch_hold", 1300, 3200, 1'b0);
      span("vco_half", 200, 320, 1'b1);
      wctl(8'h10);
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      // Crystal loss probe with a live and then a halted reference
      wbw(8'h10);
      repeat (prog[7:4] * 4) @(posedge clk_sys);
      rd_chk("xld", 4'h4, bwv(1'b0, 1'b0));
      xtalHalt <= 1'b1;
      repeat (8) @(posedge clk_sys);
      wbw(8'h10);
      repeat (prog[7:4] * 4) @(posedge clk_sys);
      rd_chk("xld", 4'h4, bwv(1'b0, 1'b1));
      xtalHalt <= 1'b0;
      // Stop while running on the VCO
      stopReq <= 1'b1;
      repeat (2) @(posedge clk_sys);
      repeat (8) begin
         @(posedge clk_sys);
         chk("stop_out", 8'h0, {4'h0, xOut, baseOut, irqOut, pll_enable});
      end
      stopReq <= 1'b0;
      sel = 1'b0;
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      span("xtal_half", 360, 480, 1'b1);
      wbw(8'h10);
      rd_chk("xld", 4'h4, bwv(1'b0, 1'b0));
      // Manual mode: lock, flag and enable stay hidden
      wbw(8'h20);
      rd_chk("bw", 4'h4, bwv(1'b0, 1'b0));
      wctl(8'hAF);
      lockReq <= 1'b1;
      repeat (20) @(posedge clk_sys);
      rd_chk("bw", 4'h4, bwv(1'b0, 1'b0));
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      // Automatic mode: entering while locked counts as a toggle
      wbw(8'hA0);
      repeat (10) @(posedge clk_sys);
      rd_chk("bw", 4'h4, bwv(1'b1, 1'b0));
      chk("tracking", {7'h0, acqReq}, {7'h0, trk});
      rd_chk("ctl", 4'h0, ctlv(1'b1));
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      wctl(8'hA0);
      lockReq <= 1'b0;
      repeat (20) @(posedge clk_sys);
      chk("irq", 8'h1, {7'h0, irqOut});
      rd_chk("ctl", 4'h0, ctlv(1'b1));
      repeat (3) @(posedge clk_sys);
      chk("irq", 8'h0, {7'h0, irqOut});
      // Back to manual: stored acquisition value returns
      wbw(8'h80);
      wbw(8'h00);
      rd_chk("bw", 4'h4, bwv(1'b0, 1'b0));
      chk("tracking", 8'h1, {7'h0, trk});
      rd_chk("ctl", 4'h0, ctlv(1'b0));
      end_sim();
   end
endmodule // tb
